//--- hdl/fad_pkg.sv
package fad_pkg;

    // Bus geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [12:0] OFS_FID = 13'h0000;
    localparam logic [12:0] OFS_DW11 = 13'h0004;
    localparam logic [12:0] OFS_CTRL = 13'h0008;
    localparam logic [12:0] OFS_STATUS = 13'h000c;
    localparam logic [12:0] OFS_CPL_DW0 = 13'h0010;
    localparam logic [12:0] OFS_RANGE_COUNT = 13'h0014;
    // Descriptor window occupies 13'h1000 to 13'h1ffc
    localparam int WIN_SEL_BIT = 12;

    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SET_BIT = 1;

    // Status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_BAD_FID_BIT = 2;
    localparam int ST_PS_BEYOND_BIT = 3;

    // Feature identifiers
    localparam logic [7:0] FID_ARB = 8'h01;
    localparam logic [7:0] FID_PM = 8'h02;
    localparam logic [7:0] FID_RANGE = 8'h03;

    // Attribute layouts; zero bits are reserved
    localparam logic [31:0] ARB_MASK = 32'hffff_ff07;
    localparam logic [31:0] PM_MASK = 32'h0000_001f;
    localparam logic [31:0] RANGE_MASK = 32'h0000_003f;
    localparam int HIGH_W_LSB = 24;
    localparam int MED_W_LSB = 16;
    localparam int LOW_W_LSB = 8;
    localparam int BURST_LSB = 0;
    localparam logic [2:0] BURST_NO_LIMIT = 3'h7;
    localparam int PS_LSB = 0;
    localparam int COUNT_LSB = 0;

    // Factory defaults, values arbitrary
    localparam logic [31:0] ARB_DEFAULT = 32'h0000_0000;
    localparam logic [31:0] PM_DEFAULT = 32'h0000_0000;
    localparam logic [5:0] COUNT_DEFAULT = 6'h00;

    // Descriptor structure: 64 entries of 64 bytes, 16 words each
    localparam int ENTRIES = 64;
    localparam int WORDS_PER_ENTRY = 16;
    localparam int BUF_WORDS = ENTRIES * WORDS_PER_ENTRY;
    localparam logic [5:0] LAST_ENTRY = 6'h3f;

    // Byte-lane merge of a bus write into an old word
    function automatic logic [31:0] apply_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Reserved bits of an attribute word forced to zero
    function automatic logic [31:0] mask_attr(input logic [31:0] w, input logic [31:0] m);
        return w & m;
    endfunction

endpackage

//--- hdl/fad_range_store.sv
`timescale 1ns/10ps
module fad_range_store
    import fad_pkg::*;
(
    // Clock
    input wire logic clk,
    // Word write port
    input wire logic wr_en,
    input wire logic [9:0] wr_index,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_be,
    // Word read port
    input wire logic [9:0] rd_index,
    output logic [31:0] rd_data,
    // Whole-entry clear
    input wire logic clr_en,
    input wire logic [5:0] clr_entry
);

    // No reset: the descriptor table persists across controller reset
    logic [31:0] mem [0:BUF_WORDS-1];

    always_ff @(posedge clk) begin
        if (clr_en) begin
            for (int w = 0; w < WORDS_PER_ENTRY; w++) begin
                mem[{clr_entry, 4'(w)}] <= 32'h0000_0000;
            end
        end else if (wr_en) begin
            mem[wr_index] <= apply_be(mem[wr_index], wr_data, wr_be);
        end
    end

    assign rd_data = mem[rd_index];

endmodule

//--- hdl/fad_top.sv
`timescale 1ns/10ps
module fad_top
    import fad_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [12:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Advertised capability
    input wire logic [4:0] supported_state_count,
    // Arbitration settings
    output logic [7:0] high_class_weight,
    output logic [7:0] medium_class_weight,
    output logic [7:0] low_class_weight,
    output logic [2:0] burst_exponent,
    output logic burst_unlimited,
    output logic [6:0] burst_limit,
    // Power and range settings
    output logic [4:0] target_power_level,
    output logic [5:0] range_count
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Register-space write strobe for one offset; lane0 also asks for byte lane 0
    function automatic logic reg_wr(input logic strobe, input logic [12:0] addr,
                                    input logic [3:0] be, input logic [12:0] ofs,
                                    input logic lane0);
        return strobe && !addr[WIN_SEL_BIT] && addr == ofs && (be[0] || !lane0);
    endfunction

    // A range set naming fewer than 64 entries must scrub the tail first
    function automatic logic needs_scrub(input logic set, input logic [7:0] id,
                                         input logic [5:0] cnt);
        return set && id == FID_RANGE && cnt != LAST_ENTRY;
    endfunction

    // Set command for one feature on the edge it starts
    function automatic logic set_cmd(input logic go, input logic set, input logic [7:0] id,
                                     input logic [7:0] want);
        return go && set && id == want;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    typedef enum logic {FAD_IDLE, FAD_CLEAR} fad_state_e;

    fad_state_e state;
    logic ack;
    logic req;
    logic win_hit;
    logic stall;
    logic wr_do;
    logic [31:0] store_rd;
    logic [31:0] reg_rd;
    logic [7:0] fid;
    logic [31:0] dw11;
    logic [31:0] arb_attr;
    logic [31:0] pm_attr;
    logic [31:0] cpl_dw0;
    logic done;
    logic bad_fid;
    logic ps_beyond;
    logic busy;
    logic start;
    logic is_set;
    logic finish;
    logic [5:0] clr_idx;
    logic [5:0] pending_count;
    logic scrub_go;
    logic scrub_last;
    logic done_clr;

    assign req = avs_read | avs_write;
    assign win_hit = avs_address[WIN_SEL_BIT];
    assign busy = (state != FAD_IDLE);
    // Table is being scrubbed; hold window accesses so nobody reads half-cleared data
    assign stall = busy & win_hit;
    assign avs_waitrequest = req & ~ack;
    assign wr_do = avs_write & ack;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack & ~stall;
        end
    end

    always_comb begin
        reg_rd = 32'h0000_0000;
        unique case (avs_address)
            OFS_FID: reg_rd = {24'h000000, fid};
            OFS_DW11: reg_rd = dw11;
            OFS_CTRL: reg_rd = 32'h0000_0000;
            OFS_STATUS: begin
                reg_rd[ST_BUSY_BIT] = busy;
                reg_rd[ST_DONE_BIT] = done;
                reg_rd[ST_BAD_FID_BIT] = bad_fid;
                reg_rd[ST_PS_BEYOND_BIT] = ps_beyond;
            end
            OFS_CPL_DW0: reg_rd = cpl_dw0;
            OFS_RANGE_COUNT: reg_rd = {26'h0000000, range_count};
            default: reg_rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack & ~stall) begin
            avs_readdata <= win_hit ? store_rd : reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command registers

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fid <= 8'h00;
        end else if (reg_wr(wr_do, avs_address, avs_byteenable, OFS_FID, 1'b1)) begin
            fid <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dw11 <= 32'h0000_0000;
        end else if (reg_wr(wr_do, avs_address, avs_byteenable, OFS_DW11, 1'b0)) begin
            dw11 <= apply_be(dw11, avs_writedata, avs_byteenable);
        end
    end

    // Commands arriving while a scrub runs are dropped, not queued
    assign start = reg_wr(wr_do, avs_address, avs_byteenable, OFS_CTRL, 1'b1)
                   && avs_writedata[CTRL_START_BIT] && state == FAD_IDLE;
    assign is_set = avs_writedata[CTRL_SET_BIT];
    assign scrub_go = start && needs_scrub(is_set, fid, dw11[COUNT_LSB +: 6]);
    assign scrub_last = (state == FAD_CLEAR) && (clr_idx == LAST_ENTRY);

    ////////////////////////////////////////////////////////////////////////////
    // Command engine

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= FAD_IDLE;
            clr_idx <= 6'h00;
            pending_count <= 6'h00;
        end else begin
            unique case (state)
                FAD_IDLE: begin
                    if (set_cmd(start, is_set, fid, FID_RANGE)) begin
                        pending_count <= dw11[COUNT_LSB +: 6];
                        if (scrub_go) begin
                            clr_idx <= dw11[COUNT_LSB +: 6] + 6'h01;
                            state <= FAD_CLEAR;
                        end
                    end
                end
                FAD_CLEAR: begin
                    clr_idx <= clr_idx + 6'h01;
                    if (scrub_last) begin
                        state <= FAD_IDLE;
                    end
                end
            endcase
        end
    end

    // Completion: same edge unless a range set needs a scrub, then after the scrub
    assign finish = (start && !needs_scrub(is_set, fid, dw11[COUNT_LSB +: 6]))
                    || scrub_last;

    ////////////////////////////////////////////////////////////////////////////
    // Feature state

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arb_attr <= ARB_DEFAULT;
        end else if (set_cmd(start, is_set, fid, FID_ARB)) begin
            arb_attr <= mask_attr(dw11, ARB_MASK);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pm_attr <= PM_DEFAULT;
        end else if (set_cmd(start, is_set, fid, FID_PM)) begin
            pm_attr <= mask_attr(dw11, PM_MASK);
        end
    end

    // Count reloads with the rest of the control state; table contents persist
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            range_count <= COUNT_DEFAULT;
        end else if (scrub_last) begin
            range_count <= pending_count;
        end else if (set_cmd(start, is_set, fid, FID_RANGE) && !scrub_go) begin
            range_count <= LAST_ENTRY;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpl_dw0 <= 32'h0000_0000;
        end else if (start) begin
            cpl_dw0 <= 32'h0000_0000;
            if (!is_set) begin
                unique case (fid)
                    FID_ARB: cpl_dw0 <= arb_attr;
                    FID_PM: cpl_dw0 <= pm_attr;
                    FID_RANGE: cpl_dw0 <= {26'h0000000, range_count};
                    default: cpl_dw0 <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status

    // Software clear of the completion flag
    assign done_clr = reg_wr(wr_do, avs_address, avs_byteenable, OFS_STATUS, 1'b1)
                      && avs_writedata[ST_DONE_BIT];

    // Completion flag: new completion wins over a software clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
        end else begin
            done <= finish | (done & ~done_clr);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bad_fid <= 1'b0;
            ps_beyond <= 1'b0;
        end else if (start) begin
            bad_fid <= (fid != FID_ARB) && (fid != FID_PM) && (fid != FID_RANGE);
            // Out-of-range level is still taken; host is expected to avoid it
            ps_beyond <= is_set && fid == FID_PM
                         && dw11[PS_LSB +: 5] > supported_state_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor table

    fad_range_store u_store (
        .clk(clk),
        .wr_en(wr_do && win_hit),
        .wr_index(avs_address[11:2]),
        .wr_data(avs_writedata),
        .wr_be(avs_byteenable),
        .rd_index(avs_address[11:2]),
        .rd_data(store_rd),
        .clr_en(state == FAD_CLEAR),
        .clr_entry(clr_idx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Settings outputs

    assign high_class_weight = arb_attr[HIGH_W_LSB +: 8];
    assign medium_class_weight = arb_attr[MED_W_LSB +: 8];
    assign low_class_weight = arb_attr[LOW_W_LSB +: 8];
    assign burst_exponent = arb_attr[BURST_LSB +: 3];
    assign burst_unlimited = (arb_attr[BURST_LSB +: 3] == BURST_NO_LIMIT);
    assign burst_limit = burst_unlimited ? 7'h00
                         : 7'(7'h01 << arb_attr[BURST_LSB +: 3]);
    assign target_power_level = pm_attr[PS_LSB +: 5];

endmodule

//--- verif/fad_host_mem.sv
`timescale 1ns/10ps
module fad_host_mem;
    // Host buffer of 64 entries, 16 words each
    function automatic logic [31:0] hword(input int i);
        case (i % 16)
            0: return 32'h0000_0101;
            // Each entry starts 256 blocks on, 256 long
            4: return {18'h0, 6'(i / 16), 8'h00};
            6: return 32'h0000_00ff;
            default: return {16'h5a00, 16'(i)};
        endcase
    endfunction
endmodule

//--- verif/fad_top_chk.sv
`timescale 1ns/10ps
module fad_top_chk
    import fad_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus
    input wire logic [12:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Settings
    input wire logic [4:0] supported_state_count,
    input wire logic [7:0] high_class_weight,
    input wire logic [7:0] medium_class_weight,
    input wire logic [7:0] low_class_weight,
    input wire logic [2:0] burst_exponent,
    input wire logic burst_unlimited,
    input wire logic [6:0] burst_limit,
    input wire logic [4:0] target_power_level,
    input wire logic [5:0] range_count
);
    logic [31:0] dw11_q;
    logic [7:0] fid_q;
    logic req;
    logic take;
    logic set_take;
    assign req = avs_read | avs_write;
    assign take = avs_write & ~avs_waitrequest;
    assign set_take = take && avs_address == OFS_CTRL && avs_writedata[1:0] == 2'b11;
    // Full-word writes only; the bench never uses partial lanes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dw11_q <= 32'h0000_0000;
            fid_q <= 8'h00;
        end else if (take && avs_address == OFS_DW11) begin
            dw11_q <= avs_writedata;
        end else if (take && avs_address == OFS_FID) begin
            fid_q <= avs_writedata[7:0];
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wait_start_a: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("new request not stalled first");
    wait_one_a: assert property (req && !$past(req) && !avs_address[WIN_SEL_BIT]
        |=> !avs_waitrequest) else $error("register access slow");
    wait_end_a: assert property (req && avs_waitrequest |-> ##[1:70] !avs_waitrequest)
        else $error("request never answered");
    arb_set_a: assert property (
        set_take && fid_q == FID_ARB |=> {high_class_weight, medium_class_weight,
        low_class_weight, burst_exponent} == {dw11_q[31:8], dw11_q[2:0]})
        else $error("arbitration outputs wrong");
    burst_flag_a: assert property (burst_unlimited == (burst_exponent == 3'h7))
        else $error("unlimited flag wrong");
    burst_lim_a: assert property (
        burst_limit == (burst_unlimited ? 7'h00 : 7'h01 << burst_exponent))
        else $error("burst limit wrong");
    pm_set_a: assert property (
        set_take && fid_q == FID_PM |=> target_power_level == dw11_q[4:0])
        else $error("power level wrong");
    settings_hold_a: assert property (!$past(set_take) |-> $stable({high_class_weight,
        medium_class_weight, low_class_weight, burst_exponent, target_power_level}))
        else $error("settings moved without a set");
    count_read_a: assert property (
        avs_read && !avs_waitrequest && avs_address == OFS_RANGE_COUNT
        |-> avs_readdata == {26'h0, range_count}) else $error("count read wrong");
endmodule
bind fad_top fad_top_chk i_chk (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .supported_state_count(supported_state_count),
    .high_class_weight(high_class_weight), .medium_class_weight(medium_class_weight),
    .low_class_weight(low_class_weight), .burst_exponent(burst_exponent),
    .burst_unlimited(burst_unlimited), .burst_limit(burst_limit),
    .target_power_level(target_power_level), .range_count(range_count)
);

//--- verif/fad_top_test.sv
`timescale 1ns/10ps
`define CHK(nm, ac, ex) begin n_tests++; if ((ac) !== (ex)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, ex, ac); end end
module fad_top_test
    import fad_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [12:0] avs_address = 13'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [4:0] supported_state_count = 5'h04;
    logic [7:0] high_class_weight, medium_class_weight, low_class_weight;
    logic [2:0] burst_exponent;
    logic burst_unlimited;
    logic [6:0] burst_limit;
    logic [4:0] target_power_level;
    logic [5:0] range_count;
    logic [34:0] arb_o;
    logic [31:0] rd;
    logic [31:0] st;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    assign arb_o = {high_class_weight, medium_class_weight, low_class_weight,
        burst_exponent, burst_unlimited, burst_limit};
    always #4 clk = ~clk;
    fad_host_mem i_host ();
    fad_top i_dut (
        .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .supported_state_count(supported_state_count),
        .high_class_weight(high_class_weight), .medium_class_weight(medium_class_weight),
        .low_class_weight(low_class_weight), .burst_exponent(burst_exponent),
        .burst_unlimited(burst_unlimited), .burst_limit(burst_limit),
        .target_power_level(target_power_level), .range_count(range_count)
    );
    ////////////////////////////////////////
    task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        if (!wr) rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic feat(input logic [7:0] fid, input logic [31:0] dw, input logic set);
        bus(1'b1, OFS_DW11, dw);
        bus(1'b1, OFS_FID, {24'h0, fid});
        bus(1'b1, OFS_CTRL, {30'h0, set, 1'b1});
    endtask
    // Poll done, keep status, clear done; hang is cut by the cycle limit
    task automatic fin();
        rd = 32'h0;
        while (rd[ST_DONE_BIT] !== 1'b1) bus(1'b0, OFS_STATUS, 32'h0);
        st = rd;
        bus(1'b1, OFS_STATUS, 32'h0000_0002);
    endtask
    task automatic get(input logic [7:0] fid, input logic [31:0] dw);
        feat(fid, dw, 1'b0);
        fin();
        bus(1'b0, OFS_CPL_DW0, 32'h0);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            results();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        `CHK("defaults", {arb_o, target_power_level, range_count}, {28'h0, 7'h01, 11'h0})
        for (int b = 0; b < 8; b++) begin
            feat(FID_ARB, 32'ha5c3_8ff8 | 32'(b), 1'b1);
            fin();
            `CHK("arb", arb_o, {24'ha5c38f, 3'(b), 1'(b == 7), 7'(b == 7 ? 0 : 1 << b)})
            get(FID_ARB, 32'h0);
            `CHK("arb get", rd, 32'ha5c3_8f00 | 32'(b))
        end
        $display("arbitration test done");
        feat(FID_PM, 32'hffff_ffe3, 1'b1);
        fin();
        `CHK("pm flags", st[3:2], 2'b00)
        get(FID_PM, 32'h0);
        `CHK("pm get", {rd, target_power_level}, {32'h3, 5'h03})
        feat(FID_PM, 32'h0000_0005, 1'b1);
        fin();
        `CHK("pm beyond", st[3], 1'b1)
        feat(8'h04, 32'h1, 1'b1);
        fin();
        `CHK("bad fid", {st[2], arb_o[34:11]}, {1'b1, 24'ha5c38f})
        $display("power test done");
        for (int i = 0; i < 1024; i++) bus(1'b1, 13'h1000 + 13'(i * 4), i_host.hword(i));
        feat(FID_RANGE, 32'hffff_ffc1, 1'b1);
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK("busy", rd[ST_BUSY_BIT], 1'b1)
        bus(1'b0, 13'h1fc0, 32'h0);
        `CHK("stalled read", rd, 32'h0)
        fin();
        for (int e = 2; e < 64; e++) begin
            bus(1'b0, 13'h1000 + 13'(e * 64), 32'h0);
            `CHK("cleared", rd, 32'h0)
        end
        bus(1'b0, 13'h1050, 32'h0);
        `CHK("kept", rd, i_host.hword(20))
        get(FID_RANGE, 32'h0000_0005);
        `CHK("range get", {rd, range_count}, {32'h1, 6'h01})
        bus(1'b0, OFS_RANGE_COUNT, 32'h0);
        `CHK("count reg", rd, 32'h0000_0001)
        bus(1'b1, 13'h0020, 32'hffff_ffff);
        bus(1'b0, 13'h0020, 32'h0);
        `CHK("unmapped", rd, 32'h0)
        $display("range test done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        `CHK("reset", {arb_o, target_power_level, range_count}, {28'h0, 7'h01, 11'h0})
        bus(1'b0, 13'h1050, 32'h0);
        `CHK("persist", rd, i_host.hword(20))
        $display("reset test done");
        results();
    end
endmodule
